// ---- logic/sfl_link.v ----
// serial flash link, pause handling, write latch and protection decode
// How it works
// - array is 2 MB: 256 B pages, 4 KB sectors, 32/64 KB blocks, 512 sectors
// - only rising link clock edges count, so idle-low and idle-high modes both work
// - inputs taken on rising link clock, outputs changed on falling link clock
// - dual reads use lanes zero and one, two bits per clock
// - quad reads use lanes zero to three, four bits per clock
// - quad reads are ignored unless the four lane enable bit is set
// - pausing stops only the link; core operations carry on
// - pause starts on pause pin low with select low once link clock is low, only while the four lane bit is clear
// - pause ends on pause pin high once link clock is low
// - while paused outputs float and link clock and inputs are ignored
// - select rising during pause resets the link state
// - latch set by its command, cleared by reset and writes, wipes, soft reset
// - protected region stays readable but rejects program and wipe
// - guard pin low with hardware lock and four lane bit clear refuses protect size and lock bit changes; complement bit stays writable
// - power-down ignores all but wake and the two step soft reset
// - protect codes with bit4 clear give 64 KB to 1 MB top or bottom
// - protect codes with bit4 set give 4 KB to 32 KB top or bottom
// - complement bit inverts the protected region exactly
// - bytes move most significant bit first from the first clock after select
// - writing commands ending off a byte boundary are discarded
`timescale 1ns/1ps
`include "sfl_defs.vh"

module sfl_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clock_i,
    input wire arst_n_i,
    input wire in_valid_i,
    input wire [WIDTH-1:0] in_data_i,
    output wire in_ready_o,
    output wire out_valid_o,
    output wire [WIDTH-1:0] out_data_o,
    input wire out_ready_i
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_wr = in_valid_i & in_ready_o;
    wire do_rd = out_valid_o & out_ready_i;
    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    // storage write
    always @(posedge clock_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
    // pointers and fill level
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_wr) begin
                wr_ptr <= (wr_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= (rd_ptr == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_ptr + 1'b1;
            end
            if (do_wr & !do_rd) begin
                count <= count + 1'b1;
            end else if (do_rd & !do_wr) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule // sfl_fifo

module sfl_link #(
    parameter [15:0] STATUS_RESET = 16'h0000,
    parameter FIFO_DEPTH = 8,
    parameter FIFO_AW = 3
) (
    input wire clock_i,
    input wire arst_n_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire lane_zero_i,
    output reg lane_zero_o,
    output wire lane_zero_oe_o,
    input wire lane_one_i,
    output reg lane_one_o,
    output wire lane_one_oe_o,
    input wire lane_two_i,
    output reg lane_two_o,
    output wire lane_two_oe_o,
    input wire lane_three_i,
    output reg lane_three_o,
    output wire lane_three_oe_o,
    input wire busy_i,
    output reg [20:0] rd_addr_o,
    input wire [7:0] rd_data_i,
    output reg op_valid_o,
    output reg [2:0] op_kind_o,
    output reg [20:0] op_addr_o,
    output wire prog_valid_o,
    output wire [7:0] prog_data_o,
    input wire prog_ready_i,
    output wire [15:0] status_o,
    output reg write_latch_flag_o,
    output reg power_down_o,
    output reg paused_o
);
    reg [5:0] sync1;
    reg [5:0] sync2;
    reg sck_d;
    reg csn_d;
    reg [15:0] st;
    reg armed;
    reg [7:0] cmd;
    reg [23:0] asr;
    reg [7:0] dsr;
    reg [15:0] cnt;
    reg [15:0] stat_new;
    reg bad;
    reg pushed;
    reg [7:0] out_sr;
    reg out_on;
    reg [2:0] aw;
    reg [2:0] dw;
    reg [7:0] ac;
    reg [7:0] dmy;
    reg is_rd;
    reg is_srd;
    reg has_addr;
    reg [20:0] sz;
    reg [20:0] prot_lo;
    reg [20:0] prot_hi;
    reg prot_any;
    reg [20:0] tmask;
    reg [15:0] wmask;
    reg [7:0] nb;
    reg [7:0] ob;
    wire sck = sync2[5];
    wire csn = sync2[4];
    wire [3:0] lin = sync2[3:0];
    wire four = st[`SFL_ST_FOUR];
    wire pause_n = four | lin[3];
    wire guard_low = !four & !lin[2];
    wire rise = sck & !sck_d & !csn & !paused_o;
    wire fall = !sck & sck_d & !csn & !paused_o;
    wire cs_end = csn & !csn_d;
    wire whole = (cnt[2:0] == 3'h0) && (cnt != 16'h0000);
    wire [7:0] dstart = is_srd ? `SFL_CMD_CLKS : `SFL_CMD_CLKS + ac + dmy;
    wire [15:0] phase = cnt - {8'h00, dstart};
    wire in_data = (cnt >= {8'h00, dstart}) & (is_rd | is_srd);
    wire [2:0] cpbm = (dw == 3'h4) ? 3'h1 : (dw == 3'h2) ? 3'h3 : 3'h7;
    wire do_load = (phase[2:0] & cpbm) == 3'h0;
    wire [20:0] tgt_lo = asr[20:0] & ~tmask;
    wire [20:0] tgt_hi = asr[20:0] | tmask;
    wire hit = prot_any & !((tgt_hi < prot_lo) | (tgt_lo > prot_hi));
    wire write_ok = write_latch_flag_o & !busy_i & !hit;
    wire hw_lock = !st[`SFL_ST_LOCK1] & st[`SFL_ST_LOCK0] & guard_low;
    wire fifo_rdy;
    wire prog_push = rise & (cmd == `SFL_CMD_PAGE_WR) & (cnt >= `SFL_PROG_DATA)
        & (cnt[2:0] == 3'h7) & write_ok & !bad & !power_down_o;
    assign status_o = {st[15:2], write_latch_flag_o, busy_i};
    assign lane_one_oe_o = out_on & !csn & !paused_o;
    assign lane_zero_oe_o = lane_one_oe_o & (dw != 3'h1);
    assign lane_two_oe_o = lane_one_oe_o & (dw == 3'h4);
    assign lane_three_oe_o = lane_two_oe_o;

    // program data buffer toward the array core
    sfl_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
        .clock_i(clock_i),
        .arst_n_i(arst_n_i),
        .in_valid_i(prog_push),
        .in_data_i({dsr[6:0], lin[0]}),
        .in_ready_o(fifo_rdy),
        .out_valid_o(prog_valid_o),
        .out_data_o(prog_data_o),
        .out_ready_i(prog_ready_i)
    );

    // command decode: lane widths and phase lengths
    always @* begin
        aw = 3'h1;
        dw = 3'h1;
        ac = `SFL_ADDR_CLKS1;
        dmy = 8'h00;
        is_rd = 1'b0;
        is_srd = 1'b0;
        has_addr = 1'b0;
        tmask = `SFL_TOP_ADDR;
        case (cmd)
            `SFL_CMD_READ: begin
                is_rd = 1'b1;
                has_addr = 1'b1;
            end
            `SFL_CMD_FAST: begin
                is_rd = 1'b1;
                has_addr = 1'b1;
                dmy = `SFL_FAST_DUMMY;
            end
            `SFL_CMD_DUAL_OUT: begin
                is_rd = 1'b1;
                has_addr = 1'b1;
                dmy = `SFL_FAST_DUMMY;
                dw = 3'h2;
            end
            `SFL_CMD_QUAD_OUT: begin
                is_rd = four;
                has_addr = 1'b1;
                dmy = `SFL_FAST_DUMMY;
                dw = 3'h4;
            end
            `SFL_CMD_DUAL_IO: begin
                is_rd = 1'b1;
                has_addr = 1'b1;
                aw = 3'h2;
                ac = `SFL_ADDR_CLKS2;
                dmy = `SFL_DIO_DUMMY;
                dw = 3'h2;
            end
            `SFL_CMD_QUAD_IO: begin
                is_rd = four;
                has_addr = four;
                aw = 3'h4;
                ac = `SFL_ADDR_CLKS4;
                dmy = `SFL_QIO_DUMMY;
                dw = 3'h4;
            end
            `SFL_CMD_STAT_RD0, `SFL_CMD_STAT_RD1: begin
                is_srd = 1'b1;
            end
            `SFL_CMD_PAGE_WR: begin
                has_addr = 1'b1;
                tmask = `SFL_PAGE_MASK;
            end
            `SFL_CMD_WIPE_4K: begin
                has_addr = 1'b1;
                tmask = `SFL_SECT_MASK;
            end
            `SFL_CMD_WIPE_32K: begin
                has_addr = 1'b1;
                tmask = `SFL_B32_MASK;
            end
            `SFL_CMD_WIPE_64K: begin
                has_addr = 1'b1;
                tmask = `SFL_B64_MASK;
            end
            default: begin
                tmask = `SFL_TOP_ADDR;
            end
        endcase
    end

    // protected range from the protect size and complement bits
    always @* begin
        if (st[6]) begin
            sz = `SFL_SECT_SIZE << (st[4] ? 3'h3 : st[4:2] - 3'h1);
        end else begin
            sz = `SFL_B64_SIZE << (st[4:2] - 3'h1);
        end
        prot_any = (st[4:2] != 3'h0);
        prot_lo = st[5] ? 21'h000000 : `SFL_TOP_ADDR - sz + 21'h000001;
        prot_hi = st[5] ? sz - 21'h000001 : `SFL_TOP_ADDR;
        if (st[4:3] == 2'h3) begin
            prot_lo = 21'h000000;
            prot_hi = `SFL_TOP_ADDR;
        end
        if (st[`SFL_ST_COMPL]) begin
            if (!prot_any || st[4:3] == 2'h3) begin
                prot_any = !prot_any;
                prot_lo = 21'h000000;
                prot_hi = `SFL_TOP_ADDR;
            end else if (st[5]) begin
                prot_lo = sz;
                prot_hi = `SFL_TOP_ADDR;
            end else begin
                prot_hi = `SFL_TOP_ADDR - sz;
                prot_lo = 21'h000000;
            end
        end
        wmask = st[`SFL_ST_LOCK1] ? 16'h0000 : hw_lock ? `SFL_ST_FREE_MASK : `SFL_ST_WR_MASK;
        if (cnt < 16'h0018) begin
            wmask = wmask & `SFL_ST_LOW_MASK;
        end
    end

    // output byte source and next shifter value
    always @* begin
        if (is_srd) begin
            ob = (cmd == `SFL_CMD_STAT_RD1) ? status_o[15:8] : status_o[7:0];
        end else begin
            ob = rd_data_i;
        end
        if (do_load) begin
            nb = ob;
        end else if (dw == 3'h4) begin
            nb = {out_sr[3:0], 4'h0};
        end else if (dw == 3'h2) begin
            nb = {out_sr[5:0], 2'h0};
        end else begin
            nb = {out_sr[6:0], 1'h0};
        end
    end

    // pin synchronisers, edge history and pause tracking
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            sync1 <= 6'h30;
            sync2 <= 6'h30;
            sck_d <= 1'b0;
            csn_d <= 1'b1;
            paused_o <= 1'b0;
        end else begin
            sync1 <= {sclk_i, cs_n_i, lane_three_i, lane_two_i, lane_one_i, lane_zero_i};
            sync2 <= sync1;
            sck_d <= sck;
            csn_d <= csn;
            if (csn) begin
                paused_o <= 1'b0;
            end else if (!sck) begin
                paused_o <= !pause_n;
            end
        end
    end

    // frame shifters, counters and read output path
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cmd <= 8'h00;
            asr <= 24'h000000;
            dsr <= 8'h00;
            cnt <= 16'h0000;
            stat_new <= 16'h0000;
            bad <= 1'b0;
            pushed <= 1'b0;
            out_sr <= 8'h00;
            out_on <= 1'b0;
            rd_addr_o <= 21'h000000;
            lane_zero_o <= 1'b0;
            lane_one_o <= 1'b0;
            lane_two_o <= 1'b0;
            lane_three_o <= 1'b0;
        end else if (csn) begin
            cnt <= 16'h0000;
            cmd <= 8'h00;
            bad <= 1'b0;
            pushed <= 1'b0;
            out_on <= 1'b0;
        end else begin
            if (rise) begin
                cnt <= cnt + 16'h0001;
                if (cnt < 16'h0008) begin
                    cmd <= {cmd[6:0], lin[0]};
                end else if (has_addr && cnt < 16'h0008 + {8'h00, ac}) begin
                    if (aw == 3'h4) begin
                        asr <= {asr[19:0], lin};
                    end else if (aw == 3'h2) begin
                        asr <= {asr[21:0], lin[1], lin[0]};
                    end else begin
                        asr <= {asr[22:0], lin[0]};
                    end
                    if (cnt == 16'h0007 + {8'h00, ac}) begin
                        if (aw == 3'h4) begin
                            rd_addr_o <= {asr[16:0], lin};
                        end else if (aw == 3'h2) begin
                            rd_addr_o <= {asr[18:0], lin[1], lin[0]};
                        end else begin
                            rd_addr_o <= {asr[19:0], lin[0]};
                        end
                    end
                end else begin
                    dsr <= {dsr[6:0], lin[0]};
                    if (cmd == `SFL_CMD_STAT_WR && cnt[2:0] == 3'h7) begin
                        if (cnt < 16'h0010) begin
                            stat_new[7:0] <= {dsr[6:0], lin[0]};
                        end else if (cnt < 16'h0018) begin
                            stat_new[15:8] <= {dsr[6:0], lin[0]};
                        end
                    end
                end
                if (prog_push) begin
                    bad <= !fifo_rdy;
                    pushed <= pushed | fifo_rdy;
                end
            end
            if (fall && in_data && !power_down_o) begin
                out_sr <= nb;
                out_on <= 1'b1;
                if (do_load && is_rd) begin
                    rd_addr_o <= rd_addr_o + 21'h000001;
                end
                lane_three_o <= (dw == 3'h4) & nb[7];
                lane_two_o <= (dw == 3'h4) & nb[6];
                lane_one_o <= (dw == 3'h4) ? nb[5] : nb[7];
                lane_zero_o <= (dw == 3'h4) ? nb[4] : nb[6];
            end
        end
    end

    // command execution at the end of a frame
    always @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st <= STATUS_RESET;
            armed <= 1'b0;
            write_latch_flag_o <= 1'b0;
            power_down_o <= 1'b0;
            op_valid_o <= 1'b0;
            op_kind_o <= 3'h0;
            op_addr_o <= 21'h000000;
        end else begin
            op_valid_o <= 1'b0;
            if (cs_end && cnt >= 16'h0008) begin
                armed <= (cmd == `SFL_CMD_RST_EN) & whole;
                op_addr_o <= tgt_lo;
                if (cmd == `SFL_CMD_RST && armed && whole) begin
                    write_latch_flag_o <= 1'b0;
                    power_down_o <= 1'b0;
                    op_valid_o <= 1'b1;
                    op_kind_o <= `SFL_OP_SOFT_RST;
                end else if (power_down_o) begin
                    power_down_o <= (cmd != `SFL_CMD_WAKE);
                end else begin
                    case (cmd)
                        `SFL_CMD_SET_LATCH: begin
                            write_latch_flag_o <= write_latch_flag_o | whole;
                        end
                        `SFL_CMD_CLR_LATCH: begin
                            write_latch_flag_o <= write_latch_flag_o & !whole;
                        end
                        `SFL_CMD_SLEEP: begin
                            power_down_o <= whole;
                        end
                        `SFL_CMD_STAT_WR: begin
                            if (whole && cnt >= 16'h0010 && write_latch_flag_o && !busy_i) begin
                                st <= (st & ~wmask) | (stat_new & wmask);
                                write_latch_flag_o <= 1'b0;
                                op_valid_o <= 1'b1;
                                op_kind_o <= `SFL_OP_STAT_WR;
                            end
                        end
                        `SFL_CMD_PAGE_WR: begin
                            if (whole && cnt > `SFL_PROG_DATA && write_ok && !bad) begin
                                write_latch_flag_o <= 1'b0;
                                op_valid_o <= 1'b1;
                                op_kind_o <= `SFL_OP_PROG;
                            end else if (pushed) begin
                                op_valid_o <= 1'b1;
                                op_kind_o <= `SFL_OP_PROG_ABORT;
                            end
                        end
                        `SFL_CMD_WIPE_4K, `SFL_CMD_WIPE_32K, `SFL_CMD_WIPE_64K: begin
                            if (whole && cnt >= `SFL_PROG_DATA && write_ok) begin
                                write_latch_flag_o <= 1'b0;
                                op_valid_o <= 1'b1;
                                op_kind_o <= (cmd == `SFL_CMD_WIPE_4K) ? `SFL_OP_WIPE_4K :
                                    (cmd == `SFL_CMD_WIPE_32K) ? `SFL_OP_WIPE_32K :
                                    `SFL_OP_WIPE_64K;
                            end
                        end
                        `SFL_CMD_WIPE_ALL_A, `SFL_CMD_WIPE_ALL_B: begin
                            if (whole && write_ok) begin
                                write_latch_flag_o <= 1'b0;
                                op_valid_o <= 1'b1;
                                op_kind_o <= `SFL_OP_WIPE_ALL;
                            end
                        end
                        default: begin
                            op_valid_o <= 1'b0;
                        end
                    endcase
                end
            end
        end
    end
endmodule // sfl_link

// ---- logic/sfl_defs.vh ----
// shared constants of the serial flash link and protect block
`ifndef SFL_DEFS_VH
`define SFL_DEFS_VH
// command codes
`define SFL_CMD_SET_LATCH 8'h06
`define SFL_CMD_CLR_LATCH 8'h04
`define SFL_CMD_STAT_WR 8'h01
`define SFL_CMD_STAT_RD0 8'h05
`define SFL_CMD_STAT_RD1 8'h35
`define SFL_CMD_READ 8'h03
`define SFL_CMD_FAST 8'h0B
`define SFL_CMD_DUAL_OUT 8'h3B
`define SFL_CMD_QUAD_OUT 8'h6B
`define SFL_CMD_DUAL_IO 8'hBB
`define SFL_CMD_QUAD_IO 8'hEB
`define SFL_CMD_PAGE_WR 8'h02
`define SFL_CMD_WIPE_4K 8'h20
`define SFL_CMD_WIPE_32K 8'h52
`define SFL_CMD_WIPE_64K 8'hD8
`define SFL_CMD_WIPE_ALL_A 8'h60
`define SFL_CMD_WIPE_ALL_B 8'hC7
`define SFL_CMD_SLEEP 8'hB9
`define SFL_CMD_WAKE 8'hAB
`define SFL_CMD_RST_EN 8'h66
`define SFL_CMD_RST 8'h99
// operation kinds handed to the array core
`define SFL_OP_PROG 3'h0
`define SFL_OP_PROG_ABORT 3'h1
`define SFL_OP_WIPE_4K 3'h2
`define SFL_OP_WIPE_32K 3'h3
`define SFL_OP_WIPE_64K 3'h4
`define SFL_OP_WIPE_ALL 3'h5
`define SFL_OP_STAT_WR 3'h6
`define SFL_OP_SOFT_RST 3'h7
// array organisation (offset masks of page, sector, blocks, array; sector and 64 KB block sizes)
`define SFL_PAGE_MASK 21'h0000FF
`define SFL_SECT_MASK 21'h000FFF
`define SFL_B32_MASK 21'h007FFF
`define SFL_B64_MASK 21'h00FFFF
`define SFL_TOP_ADDR 21'h1FFFFF
`define SFL_SECT_SIZE 21'h001000
`define SFL_B64_SIZE 21'h010000
// status bit positions and write masks
`define SFL_ST_LOCK0 7
`define SFL_ST_LOCK1 8
`define SFL_ST_FOUR 9
`define SFL_ST_COMPL 14
`define SFL_ST_WR_MASK 16'h43FC
`define SFL_ST_FREE_MASK 16'h4200
`define SFL_ST_LOW_MASK 16'h00FF
// link clock counts per phase
`define SFL_ADDR_CLKS1 8'h18
`define SFL_ADDR_CLKS2 8'h0C
`define SFL_ADDR_CLKS4 8'h06
`define SFL_FAST_DUMMY 8'h08
`define SFL_DIO_DUMMY 8'h04
`define SFL_QIO_DUMMY 8'h06
`define SFL_CMD_CLKS 8'h08
`define SFL_PROG_DATA 16'h0020
`endif

// ---- dv/sfl_link_chk.sv ----
// assertion checker for the serial flash link ports
`timescale 1ns/1ps
module sfl_link_chk (
    input wire clock_i,
    input wire arst_n_i,
    input wire sclk_i,
    input wire cs_n_i,
    input wire lane_three_i,
    input wire lane_one_oe_o,
    input wire op_valid_o,
    input wire [2:0] op_kind_o,
    input wire write_latch_flag_o,
    input wire power_down_o,
    input wire paused_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (!arst_n_i);
    // select held high long enough to pass the input synchronisers
    sequence s_still;
        cs_n_i [*4];
    endsequence
    // lanes are seen three samples late through the synchronisers
    a_hold_entry: assert property ($rose(paused_o) |-> !$past(lane_three_i, 3) &&
        !$past(sclk_i, 3) && !$past(cs_n_i, 3)) else $error("pause entered wrongly");
    a_hold_exit: assert property ($fell(paused_o) |-> $past(cs_n_i, 3) ||
        ($past(lane_three_i, 3) && !$past(sclk_i, 3))) else $error("pause left wrongly");
    a_hold_float: assert property (paused_o |-> !lane_one_oe_o) else $error("driven in pause");
    a_desel_quiet: assert property (s_still |-> !lane_one_oe_o) else $error("driven idle");
    a_desel_hold: assert property (s_still |-> !paused_o) else $error("pause kept idle");
    a_op_latch: assert property (op_valid_o && op_kind_o != 3'h1 && op_kind_o != 3'h7
        |-> $past(write_latch_flag_o)) else $error("op without latch");
    a_op_clears: assert property (op_valid_o && op_kind_o != 3'h1
        |-> ##[0:2] !write_latch_flag_o) else $error("latch not cleared");
    a_op_frame_end: assert property (op_valid_o |-> $past(cs_n_i, 3)) else $error("op mid frame");
    a_sleep_mute: assert property (power_down_o |-> !lane_one_oe_o) else $error("driven asleep");
endmodule // sfl_link_chk

bind sfl_link sfl_link_chk u_chk (.clock_i(clock_i), .arst_n_i(arst_n_i), .sclk_i(sclk_i),
    .cs_n_i(cs_n_i), .lane_three_i(lane_three_i), .lane_one_oe_o(lane_one_oe_o),
    .op_valid_o(op_valid_o), .op_kind_o(op_kind_o), .write_latch_flag_o(write_latch_flag_o),
    .power_down_o(power_down_o), .paused_o(paused_o));

// ---- dv/sfl_host_model.sv ----
// host side link controller model driving clock, select and lanes
`timescale 1ns/1ps
module sfl_host_model (
    input wire clock_i,
    input wire so_i,
    input wire so_oe_i,
    output reg sclk_o,
    output reg cs_n_o,
    output reg si_o,
    output reg guard_n_o,
    output reg pause_n_o,
    output wire so_o
);
    reg mode3 = 1'b0;
    reg noise = 1'b0;
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        si_o = 1'b0;
        guard_n_o = 1'b1;
        pause_n_o = 1'b1;
    end
    // a released output lane toggles, so stale data never passes
    always @(posedge clock_i) begin
        noise <= ~noise;
    end
    assign so_o = so_oe_i ? so_i : noise;
    task wait4;
        begin
            repeat (4) @(posedge clock_i);
            #2;
        end
    endtask
    // one frame of nbits from tx, optional pause before bit hold_at
    task frame(input [95:0] tx, input integer nbits, input integer hold_at, output [7:0] rx);
        integer i;
        begin
            sclk_o = mode3; // idle level sets the clock mode
            wait4;
            cs_n_o = 1'b0;
            wait4;
            for (i = 0; i < nbits; i = i + 1) begin
                sclk_o = 1'b0;
                if (i == hold_at) begin
                    wait4;
                    pause_n_o = 1'b0; // select low, clock low
                    repeat (4) wait4;
                    pause_n_o = 1'b1; // clock still low
                end
                si_o = tx[nbits - 1 - i]; // msb first
                wait4;
                sclk_o = 1'b1;
                rx = {rx[6:0], so_o}; // sampled on rise
                wait4;
            end
            if (!mode3) sclk_o = 1'b0;
            wait4;
            cs_n_o = 1'b1;
            repeat (2) wait4;
        end
    endtask
endmodule // sfl_host_model

// ---- dv/sfl_link_tb_top.sv ----
// self-checking bench for the serial flash link block
`timescale 1ns/1ps
module sfl_link_tb_top;
    reg clock_i = 1'b0;
    reg arst_n_i = 1'b0;
    reg prog_ready_i = 1'b0;
    integer fails = 0, n_compared = 0, n_ops = 0, drv = 0, i, j;
    reg [2:0] kind;
    reg [20:0] addr;
    reg [7:0] rx;
    reg [63:0] pexp;
    wire sclk, cs_n, si, guard_n, pause_n, l1, z0, z0e, z1, z1e, z2, z2e, z3, z3e;
    wire opv, pv, wlf, pd, pz;
    wire [20:0] ra, oa;
    wire [2:0] ok;
    wire [7:0] pdat;
    wire [15:0] st;
    always #20 clock_i = ~clock_i;
    sfl_host_model host (.clock_i(clock_i), .so_i(z1), .so_oe_i(z1e), .sclk_o(sclk),
        .cs_n_o(cs_n), .si_o(si), .guard_n_o(guard_n), .pause_n_o(pause_n), .so_o(l1));
    sfl_link DUT (.clock_i(clock_i), .arst_n_i(arst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
        .lane_zero_i(z0e ? z0 : si), .lane_zero_o(z0), .lane_zero_oe_o(z0e),
        .lane_one_i(l1), .lane_one_o(z1), .lane_one_oe_o(z1e),
        .lane_two_i(z2e ? z2 : guard_n), .lane_two_o(z2), .lane_two_oe_o(z2e),
        .lane_three_i(z3e ? z3 : pause_n), .lane_three_o(z3), .lane_three_oe_o(z3e),
        .busy_i(1'b0), .rd_addr_o(ra), .rd_data_i(ra[7:0] ^ 8'hA5), .op_valid_o(opv),
        .op_kind_o(ok), .op_addr_o(oa), .prog_valid_o(pv), .prog_data_o(pdat),
        .prog_ready_i(prog_ready_i), .status_o(st), .write_latch_flag_o(wlf),
        .power_down_o(pd), .paused_o(pz));
    // records core operations and any quad lane driving
    always @(posedge clock_i) begin
        if (opv === 1'b1) begin
            n_ops = n_ops + 1;
            kind = ok;
            addr = oa;
        end
        if (z3e === 1'b1) drv = drv + 1;
    end
    task chk(input [31:0] seen, input [31:0] exp, input [95:0] what);
        begin
            n_compared = n_compared + 1;
            if (seen !== exp) begin
                fails = fails + 1;
                $display("unexpected %0s: expected %0h seen %0h", what, exp, seen);
            end
        end
    endtask
    task f(input [95:0] tx, input integer nb);
        host.frame(tx, nb, -1, rx);
    endtask
    task end_of_test;
        begin
            $display("compared %0d, mismatches %0d", n_compared, fails);
            if (fails == 0 && n_compared > 0) begin
                $display("RESULT: PASS");
            end else begin
                $display("RESULT: FAIL");
            end
            $finish;
        end
    endtask
    // watchdog well beyond the expected run
    initial begin
        #3000000;
        fails = fails + 1;
        end_of_test;
    end
    // main sequence
    initial begin
        repeat (8) @(posedge clock_i);
        #2 arst_n_i = 1'b1;
        repeat (4) @(posedge clock_i);
        f(9'h00C, 9); chk(wlf, 0, "latch");
        f(8'h06, 8); chk(wlf, 1, "latch");
        f(8'h04, 8); chk(wlf, 0, "latch");
        f(8'h06, 8); f(24'h018400, 24); chk(st[7:2], 6'h21, "status");
        chk(wlf, 0, "latch");
        host.guard_n_o = 1'b0;
        f(8'h06, 8); f(24'h010000, 24); chk(st[7:2], 6'h21, "locked");
        host.guard_n_o = 1'b1;
        i = n_ops;
        f(8'h06, 8); f(40'h021F000011, 40); f(8'h60, 8); chk(n_ops - i, 0, "refused");
        chk(wlf, 1, "latch");
        f({8'h02, 24'h1EFF00, 64'h0123456789ABCDEF}, 96); chk(n_ops - i, 1, "ops");
        chk(kind, 0, "kind");
        chk(addr, 21'h1EFF00, "addr");
        chk(wlf, 0, "latch");
        pexp = 64'h0123456789ABCDEF;
        for (j = 0; j < 8; j = j + 1) begin
            chk(pv, 1, "fifo");
            chk(pdat, pexp[63:56], "fifo data");
            pexp = pexp << 8;
            prog_ready_i = 1'b1;
            @(posedge clock_i);
            #2 prog_ready_i = 1'b0;
        end
        chk(pv, 0, "fifo");
        fork
            host.frame({8'h03, 24'h000010, 8'h00}, 40, 32, rx);
            begin
                @(negedge pause_n);
                repeat (8) @(posedge clock_i);
                #2 chk(pz, 1, "paused");
                chk(z1e, 0, "float");
            end
        join
        chk(rx, 8'hB5, "read");
        host.mode3 = 1'b1;
        f({8'h0B, 24'h000011, 16'h0000}, 48); chk(rx, 8'hB4, "mode3");
        host.mode3 = 1'b0;
        f({8'h3B, 24'h000000, 16'h0000}, 48); chk(rx, 8'hCC, "dual");
        f({8'h6B, 24'h000000, 16'h0000}, 48); chk(drv, 0, "quad");
        f(8'h06, 8); f(24'h018402, 24); chk(st[9], 1, "four lane");
        f({8'h6B, 24'h000000, 16'h0000}, 48); chk(rx, 8'hAF, "quad");
        f(8'h06, 8); f(8'hB9, 8); chk(pd, 1, "sleep");
        f(8'h04, 8); chk(wlf, 1, "asleep");
        f(8'hAB, 8); chk(pd, 0, "wake");
        f(8'h06, 8); f(8'h66, 8); f(8'h99, 8); chk(wlf, 0, "soft reset");
        chk(kind, 7, "kind");
        end_of_test;
    end
endmodule // sfl_link_tb_top
